// *** bench/octal_dac_serial_command_decoder_bench.sv ***
// bench joining the converter target to its two-wire controller
// assumes the package, the link interface and both design ends
`timescale 1ns/100ps
`define CHK(g,e) begin n_tests++; if ((g) !== (e)) begin failures++; \
$display("[ERR] %0t got %h exp %h", $time, g, e); end end
module octal_dac_serial_command_decoder_bench import dac_link_pkg::*;;
    logic MCLK, AVS_WAITREQUEST, UPDATE, nack;
    logic RST = 1'h1, AVS_READ = 1'h0, AVS_WRITE = 1'h0;
    logic [3:0] AVS_ADDRESS = 4'h0;
    logic [31:0] AVS_WRITEDATA = 32'h0, AVS_READDATA, q;
    logic [NCH-1:0][11:0] IN_REGS, OUT_REGS;
    logic [15:0] POWER_DOWN, CLEAR_CODE, LOAD_CONTROL;
    int failures, n_tests, cyc, n_upd;
    logic [2:0] asel = 3'h5;
    localparam logic [6:0] TA = 7'h4D; // select pins start at 101
    twi_if bus();
    dac_target #(.RES(12)) u_dac_target(.MCLK(MCLK), .RST(RST), .ADDR_SEL(asel),
        .BUS(bus.target), .IN_REGS(IN_REGS), .OUT_REGS(OUT_REGS), .POWER_DOWN(POWER_DOWN),
        .CLEAR_CODE(CLEAR_CODE), .LOAD_CONTROL(LOAD_CONTROL), .UPDATE(UPDATE));
    twi_controller u_twi_controller(.MCLK(MCLK), .RST(RST), .AVS_ADDRESS(AVS_ADDRESS),
        .AVS_READ(AVS_READ), .AVS_WRITE(AVS_WRITE), .AVS_WRITEDATA(AVS_WRITEDATA),
        .AVS_READDATA(AVS_READDATA), .AVS_WAITREQUEST(AVS_WAITREQUEST), .BUS(bus.ctrl));
    twi_link_sva u_twi_link_sva(.MCLK(MCLK), .RST(RST), .scl(bus.scl), .sda(bus.sda),
        .sda_m_oe_n(bus.sda_m_oe_n), .sda_m_out(bus.sda_m_out),
        .sda_s_oe_n(bus.sda_s_oe_n), .sda_s_out(bus.sda_s_out));
    initial begin
        MCLK = 1'h0;
        forever #2 MCLK = ~MCLK;
    end
    task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge MCLK);
        AVS_WRITE <= w;
        AVS_READ <= !w;
        AVS_ADDRESS <= a;
        AVS_WRITEDATA <= d;
        do @(posedge MCLK); while (AVS_WAITREQUEST !== 1'h0);
        q = AVS_READDATA;
        AVS_WRITE <= 1'h0;
        AVS_READ <= 1'h0;
    endtask : av
    // a control write launches the link transfer, so the frame goes first
    task automatic xfer(input logic [1:0] m, input logic [6:0] a, input logic [7:0] c,
        input logic [15:0] f);
        av(1'h1, OFS_WDATA, {16'h0, f});
        av(1'h1, OFS_CTRL, {14'h0, m, c, 1'h0, a});
        do av(1'h0, OFS_STATUS, 32'h0); while (q[0] !== 1'h0);
        nack = q[1];
        av(1'h0, OFS_RDATA, 32'h0);
    endtask : xfer
    task automatic t_write;
        for (int i = 0; i < 8; i++) xfer(MODE_WRITE, TA, {CMD_WR_IN, 4'(i)}, {4'(i), 12'hA5F});
        for (int i = 0; i < 8; i++) `CHK({IN_REGS[i], OUT_REGS[i]}, {4'(i), 20'hA5000})
        xfer(MODE_WRITE, TA, {CMD_UPD, 4'h3}, 16'h0);
        `CHK({OUT_REGS[3], OUT_REGS[4]}, 24'h3A5000)
        xfer(MODE_WRITE, TA, {CMD_WR_GLOBAL, 4'h0}, 16'h7770);
        `CHK({OUT_REGS[0], OUT_REGS[6]}, 24'h7776A5)
        xfer(MODE_WRITE, TA, {CMD_WR_UPD, 4'h5}, 16'h1EF0);
        `CHK({IN_REGS[5], OUT_REGS[5], OUT_REGS[4]}, 36'h1EF1EF4A5)
        `CHK(n_upd, 3)
    endtask : t_write
    task automatic t_bcast;
        xfer(MODE_WRITE, TA, {CMD_WR_IN, CH_ALL}, 16'h3C30);
        `CHK(IN_REGS, {8{12'h3C3}})
        // pins moved away from the own address: only the broadcast match may answer
        asel <= 3'h2;
        xfer(MODE_WRITE, BCAST_ADDR, {CMD_WR_UPD, 4'h1}, 16'h2220);
        `CHK({nack, IN_REGS[1], OUT_REGS[1]}, 25'h0222222)
    endtask : t_bcast
    task automatic t_refuse;
        xfer(MODE_WRITE, TA, {CMD_WR_IN, 4'h0}, 16'h0);
        `CHK({nack, IN_REGS[0]}, 13'h13C3)
        xfer(MODE_READ_CMD, BCAST_ADDR, {RD_IN, 4'h0}, 16'h0);
        `CHK(nack, 1'h1)
        av(1'h0, 4'h2, 32'h0);
        `CHK(q[17:0], {MODE_READ_CMD, RD_IN, 4'h0, 1'h0, BCAST_ADDR})
        asel <= 3'h5;
    endtask : t_refuse
    task automatic t_reads;
        logic [7:0] cc [5] = '{{RD_IN, 4'h6}, {RD_OUT, 4'h1}, 8'h40, 8'h50, 8'h60};
        logic [15:0] ex [5] = '{16'h9870, 16'h2220, 16'h00C3, 16'h5A5F, 16'h0011};
        xfer(MODE_WRITE, TA, {CMD_WR_IN, 4'h6}, 16'h9870);
        xfer(MODE_READ_LAST, TA, 8'h0, 16'h0);
        `CHK(q[15:0], 16'h9870)
        xfer(MODE_WRITE, TA, {CMD_CLR, 4'h0}, 16'h5A5F);
        xfer(MODE_WRITE, TA, {CMD_PDN, 4'h0}, 16'h00C3);
        xfer(MODE_WRITE, TA, {CMD_LOAD_CTL, 4'h0}, 16'h0011);
        `CHK({CLEAR_CODE, POWER_DOWN, LOAD_CONTROL}, 48'h5A5F00C30011)
        for (int i = 0; i < 5; i++) begin
            xfer(MODE_READ_CMD, TA, cc[i], 16'h0);
            `CHK(q[15:0], ex[i])
        end
        xfer(MODE_WRITE, TA, {CMD_SW_RST, 4'h0}, 16'h0);
        `CHK({IN_REGS, OUT_REGS, POWER_DOWN, CLEAR_CODE, LOAD_CONTROL}, 240'h0)
    endtask : t_reads
    task automatic tally_and_finish;
        if (failures == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : tally_and_finish
    always @(posedge MCLK) begin
        if (UPDATE === 1'h1) n_upd++;
        cyc++;
        if (cyc == 90000) begin
            failures++;
            tally_and_finish();
        end
    end
    initial begin
        repeat (5) @(posedge MCLK);
        RST <= 1'h0;
        t_write();
        t_bcast();
        t_refuse();
        t_reads();
        tally_and_finish();
    end
endmodule : octal_dac_serial_command_decoder_bench

// *** bench/twi_link_sva.sv ***
// link checks between the converter target and its controller
// assumes scl far slower than MCLK and sda open drain over a pull-up
`timescale 1ns/100ps
module twi_link_sva (
    input wire logic MCLK, // system clock
    input wire logic RST, // async reset
    input wire logic scl, // link clock
    input wire logic sda, // wired data level
    input wire logic sda_m_oe_n, // controller pulls low
    input wire logic sda_m_out, // controller level
    input wire logic sda_s_oe_n, // target pulls low
    input wire logic sda_s_out // target level
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (RST);
    open_drain_a: assert property (!sda_s_oe_n || !sda_m_oe_n |-> !sda)
        else $error("link driver not open drain");
    tgt_on_low_a: assert property ($changed(sda_s_oe_n) |-> !scl && !$past(scl, 2))
        else $error("target moved sda near scl high");
    stop_release_a: assert property (scl && $rose(sda) |-> sda_s_oe_n)
        else $error("target drives at stop");
    start_free_a: assert property (scl && $fell(sda) |-> sda_s_oe_n)
        else $error("target drives at start");
    // longest legal drive is an ack plus eight low bits
    drive_bound_a: assert property ($fell(sda_s_oe_n) |-> ##[1:400] sda_s_oe_n)
        else $error("target holds sda too long");
    ack_hold_a: assert property ($fell(sda_s_oe_n) |=> !sda_s_oe_n [*8])
        else $error("target drive too short");
    master_free_a: assert property (!sda_s_oe_n && scl |-> sda_m_oe_n)
        else $error("controller drives over target data");
    scl_width_a: assert property ($rose(scl) |=> scl [*8])
        else $error("scl high too short");
endmodule : twi_link_sva

// *** hw/dac_target.sv ***
// two-wire command decoder and register file of an octal converter
// assumes scl and sda arrive unsynchronised and far slower than MCLK
// Operation
// - read clear-code or load-control register back
// - channels 0..7 selected, all ones broadcasts
// - master sends only listed command combinations
// - two data bytes go to selected registers
// - update at falling edge of last ack
// - broadcast address accepted regardless of pins
// - broadcast address never answers reads
// - acknowledge write-direction address byte
// - acknowledge the command byte
// - acknowledge read-direction address after repeated start
// - drive high data byte first
// - then drive low data byte
// - bare read returns last written register
// - data left-justified from frame bit 15
// - write codes 0..3 load and transfer
// - command byte stays in force
// - read codes return input, output, power-down
// - fixed prefix plus address-select pin levels
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/100ps
module dac_target
    import dac_link_pkg::*;
#(
    parameter int RES = RES_BITS
) (
    input wire logic MCLK, // system clock
    input wire logic RST, // asynchronous reset, active high
    input wire logic [2:0] ADDR_SEL, // address-select pin levels
    twi_if.target BUS, // two-wire link
    output logic [NCH-1:0][RES-1:0] IN_REGS, // channel input registers
    output logic [NCH-1:0][RES-1:0] OUT_REGS, // channel output registers
    output logic [FRAME_W-1:0] POWER_DOWN, // power-down register frame
    output logic [FRAME_W-1:0] CLEAR_CODE, // clear code register frame
    output logic [FRAME_W-1:0] LOAD_CONTROL, // load_control_register frame
    output logic UPDATE // one-cycle pulse when output registers change
);
    typedef enum logic [2:0] {T_IDLE, T_ADDR, T_CMD, T_HI, T_LO, T_RD_HI, T_RD_LO} tstate_t;

    tstate_t state_q;
    logic scl_m_q, scl_q, scl_p_q, sda_m_q, sda_q, sda_p_q;
    logic [2:0] asel_m_q, asel_q;
    logic [3:0] cnt_q;
    logic [7:0] rx_q, hi_q, cmd_q;
    logic [6:0] tx_q;
    logic drv_n_q, addr_ok_q, rd_q, mack_q, fresh_q;
    logic [FRAME_W-1:0] last_q, rdf_q, rd_frame, wr_frame;
    logic [RES-1:0] val;
    logic scl_rise, scl_fall, start_c, stop_c, own, bcast, accept, commit;

    function automatic logic [FRAME_W-1:0] frame_of(input logic [RES-1:0] v);
        frame_of = {v, {(FRAME_W-RES){1'b0}}};
    endfunction : frame_of

    function automatic logic hit(input logic [3:0] ch, input int i);
        hit = (ch == CH_ALL) || (ch == 4'(i));
    endfunction : hit

    // pins pass two flops before any logic reads them
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            scl_m_q <= 1'b1;
            scl_q <= 1'b1;
            scl_p_q <= 1'b1;
            sda_m_q <= 1'b1;
            sda_q <= 1'b1;
            sda_p_q <= 1'b1;
            asel_m_q <= 3'h0;
            asel_q <= 3'h0;
        end else begin
            scl_m_q <= BUS.scl;
            scl_q <= scl_m_q;
            scl_p_q <= scl_q;
            sda_m_q <= BUS.sda;
            sda_q <= sda_m_q;
            sda_p_q <= sda_q;
            asel_m_q <= ADDR_SEL;
            asel_q <= asel_m_q;
        end
    end

    assign scl_rise = scl_q & ~scl_p_q;
    assign scl_fall = ~scl_q & scl_p_q;
    assign start_c = scl_q & scl_p_q & sda_p_q & ~sda_q;
    assign stop_c = scl_q & scl_p_q & ~sda_p_q & sda_q;

    assign own = rx_q[7:1] == {ADDR_PREFIX, asel_q};
    assign bcast = rx_q[7:1] == BCAST_ADDR;
    assign accept = own | (bcast & ~rx_q[0]);

    // write lands on the scl fall that closes the ack after the low byte
    assign commit = scl_fall && cnt_q == ACK_SLOT && state_q == T_LO;
    assign wr_frame = {hi_q, rx_q};
    assign val = wr_frame[FRAME_W-1 -: RES];

    always_comb begin
        rd_frame = last_q;
        if (fresh_q) begin
            unique case (cmd_q[7:4])
                RD_IN: rd_frame = frame_of(IN_REGS[cmd_q[2:0]]);
                RD_OUT: rd_frame = frame_of(OUT_REGS[cmd_q[2:0]]);
                RD_PDN: rd_frame = POWER_DOWN;
                RD_CLR: rd_frame = CLEAR_CODE;
                RD_LOAD_CTL: rd_frame = LOAD_CONTROL;
                default: rd_frame = last_q;
            endcase
        end
    end

    // serial engine: bits in on scl rise, our drive changes on scl fall
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_q <= T_IDLE;
            cnt_q <= 4'h0;
            rx_q <= 8'h00;
            hi_q <= 8'h00;
            cmd_q <= 8'h00;
            tx_q <= 7'h7F;
            drv_n_q <= 1'b1;
            addr_ok_q <= 1'b0;
            rd_q <= 1'b0;
            mack_q <= 1'b0;
            fresh_q <= 1'b0;
            rdf_q <= '0;
        end else if (start_c) begin
            state_q <= T_ADDR;
            cnt_q <= '1; // the scl fall closing the start wraps this to zero
            drv_n_q <= 1'b1;
        end else if (stop_c) begin
            state_q <= T_IDLE;
            cnt_q <= 4'h0;
            drv_n_q <= 1'b1;
            fresh_q <= 1'b0;
        end else if (scl_rise && state_q != T_IDLE) begin
            if (cnt_q == ACK_SLOT) begin
                mack_q <= ~sda_q;
            end else begin
                rx_q <= {rx_q[6:0], sda_q};
            end
        end else if (scl_fall && state_q != T_IDLE) begin
            if (cnt_q == LAST_BIT) begin
                cnt_q <= ACK_SLOT;
                unique case (state_q)
                    T_ADDR: begin
                        drv_n_q <= ~accept;
                        addr_ok_q <= accept;
                        rd_q <= rx_q[0];
                        rdf_q <= rd_frame;
                    end
                    T_CMD, T_HI, T_LO: drv_n_q <= 1'b0;
                    default: drv_n_q <= 1'b1;
                endcase
            end else if (cnt_q == ACK_SLOT) begin
                cnt_q <= 4'h0;
                drv_n_q <= 1'b1;
                unique case (state_q)
                    T_ADDR: begin
                        if (!addr_ok_q) begin
                            state_q <= T_IDLE;
                        end else if (rd_q) begin
                            state_q <= T_RD_HI;
                            fresh_q <= 1'b0;
                            drv_n_q <= rdf_q[15];
                            tx_q <= rdf_q[14:8];
                        end else begin
                            state_q <= T_CMD;
                        end
                    end
                    T_CMD: begin
                        cmd_q <= rx_q;
                        fresh_q <= 1'b1;
                        state_q <= T_HI;
                    end
                    T_HI: begin
                        hi_q <= rx_q;
                        state_q <= T_LO;
                    end
                    T_LO: state_q <= T_HI;
                    T_RD_HI: begin
                        if (mack_q) begin
                            state_q <= T_RD_LO;
                            drv_n_q <= rdf_q[7];
                            tx_q <= rdf_q[6:0];
                        end else begin
                            state_q <= T_IDLE;
                        end
                    end
                    T_RD_LO: state_q <= T_IDLE;
                    default: state_q <= T_IDLE;
                endcase
            end else begin
                cnt_q <= cnt_q + 4'h1;
                if (state_q == T_RD_HI || state_q == T_RD_LO) begin
                    drv_n_q <= tx_q[6];
                    tx_q <= {tx_q[5:0], 1'b1};
                end
            end
        end
    end

    // register file, written only at the commit point
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            IN_REGS <= '0;
            OUT_REGS <= '0;
            POWER_DOWN <= '0;
            CLEAR_CODE <= '0;
            LOAD_CONTROL <= '0;
            last_q <= '0;
            UPDATE <= 1'b0;
        end else begin
            UPDATE <= 1'b0;
            if (commit) begin
                last_q <= wr_frame;
                unique case (cmd_q[7:4])
                    CMD_WR_IN: begin
                        for (int i = 0; i < NCH; i++) begin
                            if (hit(cmd_q[3:0], i)) IN_REGS[i] <= val;
                        end
                    end
                    CMD_UPD: begin
                        UPDATE <= 1'b1;
                        for (int i = 0; i < NCH; i++) begin
                            if (hit(cmd_q[3:0], i)) OUT_REGS[i] <= IN_REGS[i];
                        end
                    end
                    CMD_WR_GLOBAL: begin
                        UPDATE <= 1'b1;
                        for (int i = 0; i < NCH; i++) begin
                            if (hit(cmd_q[3:0], i)) begin
                                IN_REGS[i] <= val;
                                OUT_REGS[i] <= val;
                            end else begin
                                OUT_REGS[i] <= IN_REGS[i];
                            end
                        end
                    end
                    CMD_WR_UPD: begin
                        UPDATE <= 1'b1;
                        for (int i = 0; i < NCH; i++) begin
                            if (hit(cmd_q[3:0], i)) begin
                                IN_REGS[i] <= val;
                                OUT_REGS[i] <= val;
                            end
                        end
                    end
                    CMD_PDN: POWER_DOWN <= wr_frame;
                    CMD_CLR: CLEAR_CODE <= wr_frame;
                    CMD_LOAD_CTL: LOAD_CONTROL <= wr_frame;
                    CMD_SW_RST: begin
                        IN_REGS <= '0;
                        OUT_REGS <= '0;
                        POWER_DOWN <= '0;
                        CLEAR_CODE <= '0;
                        LOAD_CONTROL <= '0;
                        UPDATE <= 1'b1;
                    end
                    default: UPDATE <= 1'b0;
                endcase
            end
        end
    end

    assign BUS.sda_s_oe_n = drv_n_q;
    assign BUS.sda_s_out = 1'b0;
endmodule : dac_target

// *** hw/twi_controller.sv ***
// two-wire controller that runs converter writes and reads for software
// assumes an Avalon-MM master on MCLK and one target on the link
`timescale 1ns/100ps
module twi_controller
    import dac_link_pkg::*;
(
    input wire logic MCLK, // system clock
    input wire logic RST, // asynchronous reset, active high
    input wire logic [3:0] AVS_ADDRESS, // byte address
    input wire logic AVS_READ, // read request
    input wire logic AVS_WRITE, // write request
    input wire logic [31:0] AVS_WRITEDATA, // write data
    output logic [31:0] AVS_READDATA, // read data
    output logic AVS_WAITREQUEST, // high until the access completes
    twi_if.ctrl BUS // two-wire link
);
    typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} hstate_t;

    hstate_t state_q;
    logic [6:0] dev_q;
    logic [7:0] cmdb_q, tx_q, rxs_q;
    logic [1:0] mode_q, qtr_q;
    logic [15:0] wdata_q, rdata_q;
    logic [2:0] slot_q;
    logic [3:0] bit_q;
    logic [7:0] div_q;
    logic busy_q, nack_q, ack_ok_q, scl_o_q, oe_n_q, sda_m_q, sda_q;
    logic acc, go, tick, rx_slot;

    function automatic logic [7:0] slot_byte(input logic [2:0] s, input logic [6:0] d,
                                             input logic [7:0] c, input logic [15:0] w);
        unique case (s)
            SLOT_AW: slot_byte = {d, 1'b0};
            SLOT_CMD: slot_byte = c;
            SLOT_HI: slot_byte = w[15:8];
            SLOT_LO: slot_byte = w[7:0];
            SLOT_AR: slot_byte = {d, 1'b1};
            default: slot_byte = 8'hFF;
        endcase
    endfunction : slot_byte

    assign acc = (AVS_READ | AVS_WRITE) & ~AVS_WAITREQUEST;
    assign go = acc && AVS_WRITE && AVS_ADDRESS == OFS_CTRL && !busy_q
        && AVS_WRITEDATA[17:16] != 2'h3;
    assign tick = div_q == 8'h00;
    assign rx_slot = slot_q == SLOT_RHI || slot_q == SLOT_RLO;

    // every access waits one cycle, then completes
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            AVS_WAITREQUEST <= 1'b1;
            AVS_READDATA <= 32'h00000000;
        end else begin
            AVS_WAITREQUEST <= ~((AVS_READ | AVS_WRITE) & AVS_WAITREQUEST);
            if (AVS_READ & AVS_WAITREQUEST) begin
                unique case (AVS_ADDRESS[3:2])
                    OFS_CTRL[3:2]: AVS_READDATA <= {14'h0000, mode_q, cmdb_q, 1'b0, dev_q};
                    OFS_WDATA[3:2]: AVS_READDATA <= {16'h0000, wdata_q};
                    OFS_STATUS[3:2]: AVS_READDATA <= {30'h00000000, nack_q, busy_q};
                    OFS_RDATA[3:2]: AVS_READDATA <= {16'h0000, rdata_q};
                endcase
            end
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            dev_q <= 7'h00;
            cmdb_q <= 8'h00;
            mode_q <= MODE_WRITE;
            wdata_q <= 16'h0000;
        end else if (acc && AVS_WRITE && !busy_q) begin
            if (AVS_ADDRESS == OFS_CTRL) begin
                dev_q <= AVS_WRITEDATA[6:0];
                cmdb_q <= AVS_WRITEDATA[15:8];
                mode_q <= AVS_WRITEDATA[17:16];
            end
            if (AVS_ADDRESS == OFS_WDATA) wdata_q <= AVS_WRITEDATA[15:0];
        end
    end

    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            sda_m_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            sda_m_q <= BUS.sda;
            sda_q <= sda_m_q;
        end
    end

    // quarter-period sequencer: q0 set data, q1 scl high, q2 sample, q3 scl low
    always_ff @(posedge MCLK or posedge RST) begin
        if (RST) begin
            state_q <= H_IDLE;
            div_q <= 8'h00;
            qtr_q <= 2'h0;
            slot_q <= SLOT_AW;
            bit_q <= 4'h0;
            tx_q <= 8'hFF;
            rxs_q <= 8'h00;
            rdata_q <= 16'h0000;
            busy_q <= 1'b0;
            nack_q <= 1'b0;
            ack_ok_q <= 1'b0;
            scl_o_q <= 1'b1;
            oe_n_q <= 1'b1;
        end else if (state_q == H_IDLE) begin
            if (go) begin
                state_q <= H_START;
                slot_q <= AVS_WRITEDATA[17:16] == MODE_READ_LAST ? SLOT_AR : SLOT_AW;
                busy_q <= 1'b1;
                nack_q <= 1'b0;
                qtr_q <= 2'h0;
                div_q <= 8'(QTR_CYC - 1);
            end
        end else if (!tick) begin
            div_q <= div_q - 8'h01;
        end else begin
            div_q <= 8'(QTR_CYC - 1);
            qtr_q <= qtr_q + 2'h1;
            unique case (state_q)
                H_START: begin
                    unique case (qtr_q)
                        2'h0: oe_n_q <= 1'b1;
                        2'h1: scl_o_q <= 1'b1;
                        2'h2: oe_n_q <= 1'b0;
                        2'h3: begin
                            scl_o_q <= 1'b0;
                            state_q <= H_BYTE;
                            bit_q <= 4'h0;
                            tx_q <= slot_byte(slot_q, dev_q, cmdb_q, wdata_q);
                        end
                    endcase
                end
                H_BYTE: begin
                    unique case (qtr_q)
                        2'h0: begin
                            if (bit_q != ACK_SLOT) oe_n_q <= rx_slot | tx_q[7];
                            else oe_n_q <= !(slot_q == SLOT_RHI);
                        end
                        2'h1: scl_o_q <= 1'b1;
                        2'h2: begin
                            if (bit_q != ACK_SLOT) rxs_q <= {rxs_q[6:0], sda_q};
                            else ack_ok_q <= ~sda_q;
                        end
                        2'h3: begin
                            scl_o_q <= 1'b0;
                            if (bit_q != ACK_SLOT) begin
                                bit_q <= bit_q + 4'h1;
                                tx_q <= {tx_q[6:0], 1'b1};
                            end else if (!rx_slot && !ack_ok_q) begin
                                nack_q <= 1'b1;
                                state_q <= H_STOP;
                            end else begin
                                bit_q <= 4'h0;
                                if (slot_q == SLOT_RHI) rdata_q[15:8] <= rxs_q;
                                if (slot_q == SLOT_RLO) rdata_q[7:0] <= rxs_q;
                                if (slot_q == SLOT_CMD && mode_q == MODE_READ_CMD) begin
                                    state_q <= H_START;
                                    slot_q <= SLOT_AR;
                                end else if (slot_q == SLOT_LO || slot_q == SLOT_RLO) begin
                                    state_q <= H_STOP;
                                end else begin
                                    slot_q <= slot_q + 3'h1;
                                    tx_q <= slot_byte(slot_q + 3'h1, dev_q, cmdb_q, wdata_q);
                                end
                            end
                        end
                    endcase
                end
                H_STOP: begin
                    unique case (qtr_q)
                        2'h0: oe_n_q <= 1'b0;
                        2'h1: scl_o_q <= 1'b1;
                        2'h2: oe_n_q <= 1'b1;
                        2'h3: begin
                            busy_q <= 1'b0;
                            state_q <= H_IDLE;
                        end
                    endcase
                end
                default: state_q <= H_IDLE;
            endcase
        end
    end

    assign BUS.scl = scl_o_q;
    assign BUS.sda_m_oe_n = oe_n_q;
    assign BUS.sda_m_out = 1'b0;
endmodule : twi_controller

// *** pkg/dac_link_pkg.sv ***
// shared constants for the octal converter two-wire target and its controller
// assumes both ends run on one 250 MHz system clock
package dac_link_pkg;
    localparam int CLK_NS = 4;
    localparam int FRAME_W = 16;
    localparam int RES_BITS = 12;
    localparam int NCH = 8;
    // bit counter positions within a byte slot
    localparam logic [3:0] LAST_BIT = 4'h7;
    localparam logic [3:0] ACK_SLOT = 4'h8;
    // target addressing
    localparam logic [3:0] ADDR_PREFIX = 4'h9;
    localparam logic [6:0] BCAST_ADDR = 7'h47;
    localparam logic [3:0] CH_ALL = 4'hF;
    // upper nibble of the command_access_byte, write meaning
    localparam logic [3:0] CMD_WR_IN = 4'h0;
    localparam logic [3:0] CMD_UPD = 4'h1;
    localparam logic [3:0] CMD_WR_GLOBAL = 4'h2;
    localparam logic [3:0] CMD_WR_UPD = 4'h3;
    localparam logic [3:0] CMD_PDN = 4'h4;
    localparam logic [3:0] CMD_CLR = 4'h5;
    localparam logic [3:0] CMD_LOAD_CTL = 4'h6;
    localparam logic [3:0] CMD_SW_RST = 4'h7;
    // read meaning of the same codes
    localparam logic [3:0] RD_IN = 4'h0;
    localparam logic [3:0] RD_OUT = 4'h1;
    localparam logic [3:0] RD_PDN = 4'h4;
    localparam logic [3:0] RD_CLR = 4'h5;
    localparam logic [3:0] RD_LOAD_CTL = 4'h6;
    // controller bit timing: one serial clock is four quarters
    localparam int QTR_NS = 40;
    localparam int QTR_CYC = (QTR_NS + CLK_NS - 1) / CLK_NS;
    // controller register map, byte addresses
    localparam logic [3:0] OFS_CTRL = 4'h0;
    localparam logic [3:0] OFS_WDATA = 4'h4;
    localparam logic [3:0] OFS_STATUS = 4'h8;
    localparam logic [3:0] OFS_RDATA = 4'hC;
    localparam logic [1:0] MODE_WRITE = 2'h0;
    localparam logic [1:0] MODE_READ_CMD = 2'h1;
    localparam logic [1:0] MODE_READ_LAST = 2'h2;
    // byte slots of a controller transaction
    localparam logic [2:0] SLOT_AW = 3'h0;
    localparam logic [2:0] SLOT_CMD = 3'h1;
    localparam logic [2:0] SLOT_HI = 3'h2;
    localparam logic [2:0] SLOT_LO = 3'h3;
    localparam logic [2:0] SLOT_AR = 3'h4;
    localparam logic [2:0] SLOT_RHI = 3'h5;
    localparam logic [2:0] SLOT_RLO = 3'h6;
endpackage : dac_link_pkg

// *** pkg/twi_if.sv ***
// two-wire link between the controller and the converter target
// sda is open drain with a pull-up; scl is driven by the controller only
`timescale 1ns/100ps
interface twi_if;
    logic scl;
    logic sda_m_oe_n;
    logic sda_m_out;
    logic sda_s_oe_n;
    logic sda_s_out;
    logic sda;
    // wired-and of both drivers over the pull-up
    assign sda = (sda_m_oe_n | sda_m_out) & (sda_s_oe_n | sda_s_out);
    modport ctrl(output scl, output sda_m_oe_n, output sda_m_out, input sda);
    modport target(input scl, input sda, output sda_s_oe_n, output sda_s_out);
endinterface : twi_if
